// [rtl/msd_pkg.sv]
// Purpose: Shared constants and carrier types for the memory space decoder.
// Assumes: 16-bit program and data address buses, 16-bit data bus.
// Notes: Every address figure used by the decode logic lives here; the decoder checks also use literal addresses.
package msd_pkg;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [15:0] INT_MASK_ADDR = 16'h0004;
  localparam logic [15:0] GLOBAL_WINDOW_ADDR = 16'h0005;
  localparam logic [15:0] INT_FLAG_ADDR = 16'h0006;
  localparam logic [7:0] GLOBAL_WINDOW_RESET = 8'h00;
  localparam logic [15:0] INT_MASK_RESET = 16'h0000;
  localparam logic [15:0] INT_FLAG_RESET = 16'h0000;
  localparam int PROG_BLOCK_SEL_BIT = 12;
  localparam logic PROG_BLOCK_SEL_RESET = 1'b0;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] PROG_BOOT_LAST = 16'h1fff;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam logic [7:0] PROG_B0_PAGE_HI = 8'hff;
  localparam logic [7:0] PROG_B0_ALIAS_HI = 8'hfe;
  localparam logic [15:0] DATA_INTERNAL_LAST = 16'h7fff;
  localparam logic [15:0] SCRATCH_FIRST = 16'h0060;
  localparam logic [15:0] SCRATCH_LAST = 16'h007f;
  localparam logic [15:0] ILLEGAL_LOW_FIRST = 16'h0080;
  localparam logic [15:0] ILLEGAL_LOW_LAST = 16'h00ff;
  localparam logic [7:0] DATA_B0_ALIAS_HI = 8'h01;
  localparam logic [7:0] DATA_B0_PAGE_HI = 8'h02;
  localparam logic [7:0] DATA_B1_PAGE_HI = 8'h03;
  localparam logic [7:0] DATA_B1_ILLEGAL_HI = 8'h04;
  localparam logic [15:0] TEST_AREA_FIRST = 16'h002b;
  localparam logic [15:0] TEST_AREA_LAST = 16'h002f;
  localparam int PAGE_BITS = 9;
  localparam int OFFSET_BITS = 7;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef enum logic [1:0] {
    MSD_PT_NONE = 2'b00,
    MSD_PT_FLASH = 2'b01,
    MSD_PT_BLOCK0 = 2'b10,
    MSD_PT_EXTERNAL = 2'b11
  } msd_prog_target_t;

  typedef enum logic [2:0] {
    MSD_DT_NONE = 3'b000,
    MSD_DT_REGISTER = 3'b001,
    MSD_DT_SCRATCH = 3'b010,
    MSD_DT_BLOCK0 = 3'b011,
    MSD_DT_BLOCK1 = 3'b100,
    MSD_DT_INTERNAL = 3'b101,
    MSD_DT_EXTERNAL = 3'b110,
    MSD_DT_ILLEGAL = 3'b111
  } msd_data_target_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic direct;
    logic [15:0] addr;
    logic [15:0] wdata;
  } msd_data_req_t;

  typedef struct packed {
    msd_data_target_t target;
    logic [15:0] addr;
    logic ext_strobe_n;
    logic global_req;
  } msd_data_sel_t;

endpackage

// [rtl/msd_data_decode.sv]
// Purpose: Combinational data-space decode for one access.
// Assumes: Address already formed; global window value is current.
// Notes: Purely combinational so register changes act on the next access.
`timescale 1ns/1ps
`default_nettype none
module msd_data_decode (
  input wire logic [15:0] addr_in,
  input wire logic prog_block_select_in,
  input wire logic [7:0] global_window_in,
  output msd_pkg::msd_data_target_t target_out,
  output logic [15:0] phys_addr_out,
  output logic global_out
);

  always_comb begin
    target_out = msd_pkg::MSD_DT_INTERNAL;
    phys_addr_out = addr_in;
    global_out = 1'b0;
    if (addr_in > msd_pkg::DATA_INTERNAL_LAST) begin
      target_out = msd_pkg::MSD_DT_EXTERNAL;
      // Global when the window is nonzero and every set window bit matches a one in the address top byte.
      global_out = (global_window_in != 8'h00) &&
                   ((addr_in[15:8] & global_window_in) == global_window_in);
    end else if (addr_in == msd_pkg::INT_MASK_ADDR ||
                 addr_in == msd_pkg::GLOBAL_WINDOW_ADDR ||
                 addr_in == msd_pkg::INT_FLAG_ADDR) begin
      target_out = msd_pkg::MSD_DT_REGISTER;
    end else if (addr_in >= msd_pkg::SCRATCH_FIRST && addr_in <= msd_pkg::SCRATCH_LAST) begin
      target_out = msd_pkg::MSD_DT_SCRATCH;
    end else if (addr_in >= msd_pkg::ILLEGAL_LOW_FIRST &&
                 addr_in <= msd_pkg::ILLEGAL_LOW_LAST) begin
      target_out = msd_pkg::MSD_DT_ILLEGAL;
    end else if (addr_in[15:8] == msd_pkg::DATA_B0_ALIAS_HI ||
                 addr_in[15:8] == msd_pkg::DATA_B0_PAGE_HI) begin
      // Block zero sits in data space only while it is not given to program space.
      if (prog_block_select_in) begin
        target_out = msd_pkg::MSD_DT_ILLEGAL;
      end else begin
        target_out = msd_pkg::MSD_DT_BLOCK0;
        phys_addr_out = {msd_pkg::DATA_B0_PAGE_HI, addr_in[7:0]};
      end
    end else if (addr_in[15:8] == msd_pkg::DATA_B1_PAGE_HI) begin
      target_out = msd_pkg::MSD_DT_BLOCK1;
    end else if (addr_in[15:8] == msd_pkg::DATA_B1_ILLEGAL_HI) begin
      target_out = msd_pkg::MSD_DT_ILLEGAL;
    end
  end

endmodule
`default_nettype wire

// [rtl/msd_decoder.sv]
// Purpose: Program and data space decoder with the three zero-wait registers.
// Assumes: One access per bus per cycle, qualified by a valid strobe.
// Notes: Selects are combinational upstream and registered once at the outputs.
// What this block does
// - Select bit set maps block zero into program space, else external.
// - Select bit clears on reset so block zero starts in data space.
// - Boot pin low serves program 0000h-1FFFh from on-chip flash.
// - Boot pin high sends program 0000h-1FFFh off chip.
// - Reset vector always fetched at program address 0000h.
// - Data below 8000h is internal; 8000h and up is external.
// - Blocks one and two are data only; block zero moves spaces.
// - Direct address is 9-bit page pointer above 7-bit offset.
// - Mask, window and flag registers answer with zero wait states.
// - Scratch block at 0060h-007Fh, reachable by every addressing mode.
// - Window register at 0005h, 8 low bits, read/write, resets zero.
// - Window leading ones pick a global region at top of data space.
// - External data access drives strobe low; global region adds request.
// - Illegal address access raises a nonmaskable interrupt.
// - Data 0100h-01FFh aliases 0200h; program FE00h aliases FF00h.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic boot_source_select_in,
  input wire logic [15:0] status_word_one_in,
  input wire logic [8:0] page_pointer_in,
  input wire logic prog_valid_in,
  input wire logic [15:0] prog_addr_in,
  input wire logic reset_fetch_in,
  input wire msd_pkg::msd_data_req_t data_req_in,
  output msd_pkg::msd_prog_target_t prog_target_out,
  output logic [15:0] prog_addr_out,
  output msd_pkg::msd_data_sel_t data_sel_out,
  output logic data_space_strobe_n_out,
  output logic global_access_request_out,
  output logic [15:0] reg_rdata_out,
  output logic [15:0] int_mask_out,
  output logic [15:0] int_flag_out,
  output logic [7:0] global_window_out,
  output logic prog_block_select_out,
  output logic nmi_out
);

  // ****************************************
  // Boot pin synchroniser
  // ****************************************
  logic [2:0] boot_sync_reg;
  logic [2:0] boot_sync_next;
  logic boot_level_reg;
  logic boot_level_next;

  always_comb begin
    boot_sync_next = {boot_sync_reg[1:0], boot_source_select_in};
    boot_level_next = boot_level_reg;
    if (boot_sync_reg[2] == boot_sync_reg[1]) begin
      boot_level_next = boot_sync_reg[2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      boot_sync_reg <= 3'h0;
      boot_level_reg <= 1'b0;
    end else begin
      boot_sync_reg <= boot_sync_next;
      boot_level_reg <= boot_level_next;
    end
  end

  // ****************************************
  // Registers at 0004h to 0006h
  // ****************************************
  logic [15:0] int_mask_reg;
  logic [15:0] int_mask_next;
  logic [15:0] int_flag_reg;
  logic [15:0] int_flag_next;
  logic [7:0] global_window_reg;
  logic [7:0] global_window_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] data_addr;
  logic reg_write;

  always_comb begin
    // Direct accesses build the address from page pointer and offset.
    data_addr = data_req_in.addr;
    if (data_req_in.direct) begin
      data_addr = {page_pointer_in, data_req_in.addr[msd_pkg::OFFSET_BITS-1:0]};
    end
    reg_write = data_req_in.valid && data_req_in.write;
    int_mask_next = int_mask_reg;
    int_flag_next = int_flag_reg;
    global_window_next = global_window_reg;
    rdata_next = rdata_reg;
    if (reg_write && data_addr == msd_pkg::INT_MASK_ADDR) begin
      int_mask_next = data_req_in.wdata;
    end
    if (reg_write && data_addr == msd_pkg::INT_FLAG_ADDR) begin
      int_flag_next = data_req_in.wdata;
    end
    if (reg_write && data_addr == msd_pkg::GLOBAL_WINDOW_ADDR) begin
      global_window_next = data_req_in.wdata[7:0];
    end
    if (data_req_in.valid && !data_req_in.write) begin
      unique case (data_addr)
        msd_pkg::INT_MASK_ADDR: rdata_next = int_mask_reg;
        msd_pkg::GLOBAL_WINDOW_ADDR: rdata_next = {8'h00, global_window_reg};
        msd_pkg::INT_FLAG_ADDR: rdata_next = int_flag_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      int_mask_reg <= msd_pkg::INT_MASK_RESET;
      int_flag_reg <= msd_pkg::INT_FLAG_RESET;
      global_window_reg <= msd_pkg::GLOBAL_WINDOW_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      int_mask_reg <= int_mask_next;
      int_flag_reg <= int_flag_next;
      global_window_reg <= global_window_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Program space decode
  // ****************************************
  logic prog_block_select;
  msd_pkg::msd_prog_target_t prog_target_next;
  msd_pkg::msd_prog_target_t prog_target_reg;
  logic [15:0] prog_addr_next;
  logic [15:0] prog_addr_reg;

  // The core resets its status word, so the select bit reads zero after reset.
  assign prog_block_select = sys_rst_in ? msd_pkg::PROG_BLOCK_SEL_RESET
                                        : status_word_one_in[msd_pkg::PROG_BLOCK_SEL_BIT];

  always_comb begin
    prog_target_next = msd_pkg::MSD_PT_NONE;
    prog_addr_next = reset_fetch_in ? msd_pkg::RESET_VECTOR_ADDR : prog_addr_in;
    if (prog_valid_in || reset_fetch_in) begin
      prog_target_next = msd_pkg::MSD_PT_EXTERNAL;
      if (prog_addr_next <= msd_pkg::PROG_BOOT_LAST) begin
        prog_target_next = boot_level_reg ? msd_pkg::MSD_PT_EXTERNAL
                                          : msd_pkg::MSD_PT_FLASH;
      end else if (prog_block_select && (prog_addr_next[15:8] == msd_pkg::PROG_B0_PAGE_HI ||
                   prog_addr_next[15:8] == msd_pkg::PROG_B0_ALIAS_HI)) begin
        prog_target_next = msd_pkg::MSD_PT_BLOCK0;
        prog_addr_next = {msd_pkg::PROG_B0_PAGE_HI, prog_addr_next[7:0]};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prog_target_reg <= msd_pkg::MSD_PT_NONE;
      prog_addr_reg <= 16'h0000;
    end else begin
      prog_target_reg <= prog_target_next;
      prog_addr_reg <= prog_addr_next;
    end
  end

  // ****************************************
  // Data space decode and external strobes
  // ****************************************
  msd_pkg::msd_data_target_t data_target;
  logic [15:0] data_phys;
  logic data_global;
  msd_pkg::msd_data_sel_t data_sel_next;
  msd_pkg::msd_data_sel_t data_sel_reg;
  logic nmi_next;
  logic nmi_reg;
  logic pbs_reg;

  msd_data_decode msd_data_decode_inst (
    .addr_in(data_addr),
    .prog_block_select_in(prog_block_select),
    .global_window_in(global_window_reg),
    .target_out(data_target),
    .phys_addr_out(data_phys),
    .global_out(data_global)
  );

  always_comb begin
    data_sel_next = '{target: msd_pkg::MSD_DT_NONE, addr: data_phys,
                      ext_strobe_n: 1'b1, global_req: 1'b0};
    nmi_next = 1'b0;
    if (data_req_in.valid) begin
      data_sel_next.target = data_target;
      if (data_target == msd_pkg::MSD_DT_EXTERNAL) begin
        data_sel_next.ext_strobe_n = 1'b0;
        data_sel_next.global_req = data_global;
      end
      nmi_next = (data_target == msd_pkg::MSD_DT_ILLEGAL);
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      data_sel_reg <= '{target: msd_pkg::MSD_DT_NONE, addr: 16'h0000,
                        ext_strobe_n: 1'b1, global_req: 1'b0};
      nmi_reg <= 1'b0;
      pbs_reg <= msd_pkg::PROG_BLOCK_SEL_RESET;
    end else begin
      data_sel_reg <= data_sel_next;
      nmi_reg <= nmi_next;
      pbs_reg <= prog_block_select;
    end
  end

  assign prog_target_out = prog_target_reg;
  assign prog_addr_out = prog_addr_reg;
  assign data_sel_out = data_sel_reg;
  assign data_space_strobe_n_out = data_sel_reg.ext_strobe_n;
  assign global_access_request_out = data_sel_reg.global_req;
  assign reg_rdata_out = rdata_reg;
  assign int_mask_out = int_mask_reg;
  assign int_flag_out = int_flag_reg;
  assign global_window_out = global_window_reg;
  assign prog_block_select_out = pbs_reg;
  assign nmi_out = nmi_reg;

  // ****************************************
  // Checks
  // ****************************************
  ext_strobe_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_req_in.valid && data_addr > msd_pkg::DATA_INTERNAL_LAST |=> !data_space_strobe_n_out)
    else $error("External data access did not drive the strobe low.");
  internal_quiet_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_req_in.valid && data_addr <= msd_pkg::DATA_INTERNAL_LAST |=>
    data_space_strobe_n_out && !global_access_request_out)
    else $error("Internal data access drove an external strobe.");
  global_top_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_req_in.valid && global_window_reg == 8'hff && data_addr[15:8] == 8'hff |=>
    global_access_request_out)
    else $error("Top page not global with full window.");
  global_none_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    global_window_reg == 8'h00 |=> !global_access_request_out)
    else $error("Global request with empty window.");
  window_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reg_write && data_addr == msd_pkg::GLOBAL_WINDOW_ADDR |=>
    global_window_out == $past(data_req_in.wdata[7:0]))
    else $error("Window register did not take the written byte.");
  boot_flash_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !boot_level_reg && reset_fetch_in |=> prog_target_out == msd_pkg::MSD_PT_FLASH)
    else $error("Reset fetch not from flash in microcomputer mode.");
  boot_ext_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    boot_level_reg && prog_valid_in && prog_addr_in <= msd_pkg::PROG_BOOT_LAST |=>
    prog_target_out == msd_pkg::MSD_PT_EXTERNAL)
    else $error("Low program access not external in microprocessor mode.");
  vector_addr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reset_fetch_in |=> prog_addr_out == msd_pkg::RESET_VECTOR_ADDR)
    else $error("Reset vector fetched away from 0000h.");
  illegal_nmi_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_req_in.valid && data_addr[15:7] == 9'h001 |=> nmi_out)
    else $error("Illegal data access raised no interrupt.");
  direct_page_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_req_in.valid && data_req_in.direct && page_pointer_in == 9'h000 &&
    data_req_in.addr[6:0] == 7'h04 && !data_req_in.write |=> reg_rdata_out == $past(int_mask_reg))
    else $error("Direct access on page zero missed the mask register.");

endmodule
`default_nettype wire

// [test/msd_ext_bus_model.sv]
// Purpose: External memory bus model that tallies data strobes and global requests.
// Assumes: Strobe is active low and one cycle long per external data access.
// Notes: Passive; the bench compares its tallies with its own expectations.
`timescale 1ns/1ps
`default_nettype none
module msd_ext_bus_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic data_space_strobe_n_in,
  input wire logic global_access_request_in,
  output logic [15:0] ext_count_out,
  output logic [15:0] glb_count_out
);
  // ****************************************
  // Access tallies
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ext_count_out <= 16'h0000;
      glb_count_out <= 16'h0000;
    end else if (!data_space_strobe_n_in) begin
      ext_count_out <= ext_count_out + 16'h0001;
      glb_count_out <= glb_count_out + {15'h0000, global_access_request_in};
    end
  end
endmodule
`default_nettype wire

// [test/test_msd_decoder.sv]
// Purpose: Self-checking bench for the memory space decoder.
// Assumes: One-cycle answer latency and a three-flop boot pin synchroniser.
// Notes: Accesses are held back to back; idle drops every request.
`timescale 1ns/1ps
`default_nettype none
module test_msd_decoder;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic boot_source_select_in = 1'b0;
  logic [15:0] status_word_one_in = 16'h0000;
  logic [8:0] page_pointer_in = 9'h000;
  logic prog_valid_in = 1'b0;
  logic [15:0] prog_addr_in = 16'h0000;
  logic reset_fetch_in = 1'b0;
  msd_pkg::msd_data_req_t data_req_in = '0;
  msd_pkg::msd_prog_target_t prog_target_out;
  logic [15:0] prog_addr_out;
  msd_pkg::msd_data_sel_t data_sel_out;
  logic data_space_strobe_n_out;
  logic global_access_request_out;
  logic [15:0] reg_rdata_out;
  logic [15:0] int_mask_out;
  logic [15:0] int_flag_out;
  logic [7:0] global_window_out;
  logic prog_block_select_out;
  logic nmi_out;
  logic [15:0] ext_count;
  logic [15:0] glb_count;
  logic [7:0] win;
  logic [15:0] lo;
  int err_total = 0;
  int n_checks = 0;
  int exp_ext = 0;
  int exp_glb = 0;

  msd_decoder msd_decoder_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .boot_source_select_in(boot_source_select_in), .status_word_one_in(status_word_one_in),
    .page_pointer_in(page_pointer_in), .prog_valid_in(prog_valid_in),
    .prog_addr_in(prog_addr_in), .reset_fetch_in(reset_fetch_in), .data_req_in(data_req_in),
    .prog_target_out(prog_target_out), .prog_addr_out(prog_addr_out),
    .data_sel_out(data_sel_out), .data_space_strobe_n_out(data_space_strobe_n_out),
    .global_access_request_out(global_access_request_out), .reg_rdata_out(reg_rdata_out),
    .int_mask_out(int_mask_out), .int_flag_out(int_flag_out),
    .global_window_out(global_window_out), .prog_block_select_out(prog_block_select_out),
    .nmi_out(nmi_out));

  msd_ext_bus_model msd_ext_bus_model_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .data_space_strobe_n_in(data_space_strobe_n_out),
    .global_access_request_in(global_access_request_out),
    .ext_count_out(ext_count), .glb_count_out(glb_count));

  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic data_acc(input logic wr, input logic dr, input logic [15:0] a,
                          input logic [15:0] wd);
    if (wr) chk(a >= 16'h002b && a <= 16'h002f, 1'b0);
    data_req_in = '{valid: 1'b1, write: wr, direct: dr, addr: a, wdata: wd};
    @(posedge clock_in);
    #1;
  endtask

  task automatic dsel(input logic [15:0] a, input logic [2:0] t, input logic [15:0] pa);
    data_acc(1'b0, 1'b0, a, 16'h0000);
    chk(data_sel_out.target, t);
    chk(data_sel_out.addr, pa);
  endtask

  task automatic dchk(input logic en, input logic eg);
    chk(data_space_strobe_n_out, en);
    chk(global_access_request_out, eg);
    if (!en) exp_ext++;
    if (eg) exp_glb++;
  endtask

  task automatic prog_acc(input logic [15:0] a, input logic rf, input logic [1:0] t,
                          input logic [15:0] pa);
    prog_valid_in = 1'b1;
    prog_addr_in = a;
    reset_fetch_in = rf;
    @(posedge clock_in);
    #1;
    chk(prog_target_out, t);
    chk(prog_addr_out, pa);
  endtask

  task automatic idle(input int n);
    data_req_in.valid = 1'b0;
    prog_valid_in = 1'b0;
    reset_fetch_in = 1'b0;
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    chk(global_window_out, 8'h00);
    chk(prog_block_select_out, 1'b0);
    chk(data_space_strobe_n_out, 1'b1);
    data_acc(1'b1, 1'b0, 16'h0004, 16'hffff);
    chk(int_mask_out, 16'hffff);
    data_acc(1'b1, 1'b0, 16'h0006, 16'h00a5);
    chk(int_flag_out, 16'h00a5);
    data_acc(1'b1, 1'b0, 16'h0005, 16'hab80);
    chk(global_window_out, 8'h80);
    data_acc(1'b0, 1'b0, 16'h0004, 16'h0000);
    chk(reg_rdata_out, 16'hffff);
    data_acc(1'b0, 1'b0, 16'h0005, 16'h0000);
    chk(reg_rdata_out, 16'h0080);
    data_acc(1'b0, 1'b0, 16'h0006, 16'h0000);
    chk(reg_rdata_out, 16'h00a5);
    data_acc(1'b0, 1'b0, 16'h0007, 16'h0000);
    chk(reg_rdata_out, 16'h0000);
    idle(1);
    chk(reg_rdata_out, 16'h0000);
    for (int i = 0; i <= 8; i++) begin
      win = 8'hff << (8 - i);
      data_acc(1'b1, 1'b0, 16'h0005, {8'h00, win});
      lo = (i == 0) ? 16'h8000 : {win, 8'h00};
      data_acc(1'b0, 1'b0, lo, 16'h0000);
      dchk(1'b0, i != 0);
      chk(data_sel_out.target, msd_pkg::MSD_DT_EXTERNAL);
      data_acc(1'b0, 1'b0, lo - 16'h0001, 16'h0000);
      dchk(i <= 1, 1'b0);
    end
    dsel(16'h0060, msd_pkg::MSD_DT_SCRATCH, 16'h0060);
    dsel(16'h007f, msd_pkg::MSD_DT_SCRATCH, 16'h007f);
    data_acc(1'b0, 1'b1, 16'h1fe0, 16'h0000);
    chk(data_sel_out.addr, 16'h0060);
    data_acc(1'b0, 1'b1, 16'h3f84, 16'h0000);
    chk(reg_rdata_out, 16'hffff);
    page_pointer_in = 9'h100;
    data_acc(1'b0, 1'b1, 16'h0005, 16'h0000);
    chk(data_sel_out.addr, 16'h8005);
    dchk(1'b0, 1'b0);
    dsel(16'h0150, msd_pkg::MSD_DT_BLOCK0, 16'h0250);
    data_acc(1'b0, 1'b0, 16'h0400, 16'h0000);
    chk(nmi_out, 1'b1);
    dsel(16'h0300, msd_pkg::MSD_DT_BLOCK1, 16'h0300);
    chk(nmi_out, 1'b0);
    status_word_one_in = 16'h1000;
    data_acc(1'b0, 1'b0, 16'h0200, 16'h0000);
    chk(data_sel_out.target, msd_pkg::MSD_DT_ILLEGAL);
    chk(prog_block_select_out, 1'b1);
    dsel(16'h0300, msd_pkg::MSD_DT_BLOCK1, 16'h0300);
    idle(1);
    prog_acc(16'hfe10, 1'b0, msd_pkg::MSD_PT_BLOCK0, 16'hff10);
    prog_acc(16'hff20, 1'b0, msd_pkg::MSD_PT_BLOCK0, 16'hff20);
    status_word_one_in = 16'h0000;
    prog_acc(16'hff20, 1'b0, msd_pkg::MSD_PT_EXTERNAL, 16'hff20);
    prog_acc(16'h1fff, 1'b0, msd_pkg::MSD_PT_FLASH, 16'h1fff);
    prog_acc(16'h2000, 1'b0, msd_pkg::MSD_PT_EXTERNAL, 16'h2000);
    prog_acc(16'h1234, 1'b1, msd_pkg::MSD_PT_FLASH, 16'h0000);
    boot_source_select_in = 1'b1;
    idle(4);
    prog_acc(16'h0000, 1'b0, msd_pkg::MSD_PT_EXTERNAL, 16'h0000);
    prog_acc(16'h1fff, 1'b0, msd_pkg::MSD_PT_EXTERNAL, 16'h1fff);
    prog_acc(16'h5555, 1'b1, msd_pkg::MSD_PT_EXTERNAL, 16'h0000);
    status_word_one_in = 16'h1000;
    idle(2);
    chk(ext_count, exp_ext[15:0]);
    chk(glb_count, exp_glb[15:0]);
    sys_rst_in = 1'b1;
    idle(2);
    chk(prog_block_select_out, 1'b0);
    chk(global_window_out, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
